// ---- cfgpp_pkg.sv ----
// constants, modes and states of the configuration peripheral port
// assumes a 10 MHz system clock shared by every user of the package
package cfgpp_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 100;
   localparam int MASTER_WAIT_MIN_NS = 30000;
   localparam int MASTER_WAIT_MAX_NS = 300000;
   // least time, rounded up to whole cycles
   localparam int MASTER_WAIT_CYC    = (MASTER_WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MASTER_WAIT_MAX_CYC = MASTER_WAIT_MAX_NS / CLK_PERIOD_NS;
   localparam int CLEAR_CYC_DEFAULT  = 64;

   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int ADDR_W     = 18;
   localparam int ADDR_EXT_W = 4;
   localparam int DATA_W     = 8;
   localparam int PIN_W      = 16;
   // pin bundle: {mode[2:0], data[7:0], rs, ws, cs_high, cs_low, init}
   localparam int PIN_INIT   = 0;
   localparam int PIN_CSL    = 1;
   localparam int PIN_CSH    = 2;
   localparam int PIN_WS     = 3;
   localparam int PIN_RS     = 4;
   localparam int PIN_DATA   = 5;
   localparam int PIN_MODE   = 13;
   localparam logic [PIN_W-1:0] PIN_RST = 16'h001A;
   localparam logic [DATA_W-2:0] STATUS_FILL = 7'h7F;

   // ------------------------------------------------------------
   // configuration modes
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_MASTER_SER = 3'h0;
   localparam logic [2:0] MODE_MASTER_PAR = 3'h6;
   localparam logic [2:0] MODE_PERIPH     = 3'h5;
   localparam logic [2:0] MODE_EXPRESS    = 3'h4;
   localparam logic [2:0] MODE_SLAVE_SER  = 3'h7;

   typedef enum logic [2:0] {
      ST_CLEAR,
      ST_WAIT,
      ST_MDELAY,
      ST_CONFIG,
      ST_ERROR,
      ST_DONE
   } cfgpp_state_type;

endpackage

// ---- cfgpp_sync3.sv ----
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
module cfgpp_sync3 #(
   parameter int              W   = 1,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic          clk,      // system clock
   input  wire logic          rst_b,    // async reset, active low
   input  wire logic [W-1:0]  pin_in,   // raw pins
   output logic      [W-1:0]  pin_s     // filtered level
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   if (W < 1) begin : g_bad_width
      $error("W must be at least 1");
   end

   // a change counts only when stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               pin_s[i] <= RST[i];
            end else if (s2_q[i] == s3_q[i]) begin
               pin_s[i] <= s3_q[i];
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_sync_agree: assert property ($changed(pin_s) |-> $past(s2_q) == $past(s3_q)
                                  && pin_s == $past(s3_q))
      else $error("filtered pin changed without stage agreement");

endmodule

// ---- cfgpp_loader.sv ----
// configuration clear/hold handshake, async peripheral port and parallel rom addressing
// assumes a configuration engine on clk that consumes bytes and reports errors and done
//
// What this block does
// - hold the clear/hold pin low during power-up and memory clearing
// - stay waiting, not configuring, while someone else holds that pin low
// - master modes wait a further 30 to 300 us after pin release
// - pull the clear/hold pin low on a configuration data error
// - selected only while chip_select_low low and chip_select_high high
// - selected write strobe going low captures the data bus byte into the buffer if it is empty
// - selected read strobe drives bit 7 ready/busy, other bits high
// - both strobes low: do the write, ignore the read
// - express mode uses chip_select_high as a daisy-chain serial enable
// - master parallel mode drives the 18-bit rom address
// - wide variants also drive four extra high address bits
// - after configuration release select and strobe pins to user logic
// - byte_accept_indicator shows when the next byte may be written
// - sample the mode pins after the clear/hold pin goes high
`timescale 1ns/100ps
module cfgpp_loader
   import cfgpp_pkg::*;
#(
   parameter int CLEAR_CYC = cfgpp_pkg::CLEAR_CYC_DEFAULT,
   parameter bit WIDE_ADDR = 1'b1
) (
   input  wire logic                              clk,                    // system clock, 10 MHz
   input  wire logic                              rst_b,                  // async reset, active low
   input  wire logic                              init_in,                // clear/hold pin level
   output logic                                   init_out,               // clear/hold drive value
   output logic                                   init_oe,                // clear/hold drive enable
   input  wire logic [2:0]                        config_mode_select,     // mode pins
   input  wire logic                              chip_select_low,        // select, active low
   input  wire logic                              chip_select_high,       // select, active high
   input  wire logic                              write_strobe_n,         // write strobe
   input  wire logic                              read_strobe_n,          // read strobe
   input  wire logic [cfgpp_pkg::DATA_W-1:0]      peripheral_data_in,     // data bus level
   output logic      [cfgpp_pkg::DATA_W-1:0]      peripheral_data_out,    // data bus drive value
   output logic                                   peripheral_data_oe,     // data bus drive enable
   output logic                                   byte_accept_indicator,  // high when ready
   output logic                                   byte_accept_oe,         // ready pin drive enable
   output logic      [cfgpp_pkg::ADDR_W-1:0]      config_rom_address,     // rom address
   output logic      [cfgpp_pkg::ADDR_EXT_W-1:0]  config_rom_address_ext, // rom address high bits
   output logic                                   rom_addr_oe,            // address drive enable
   input  wire logic                              rom_next,               // engine took a rom byte
   output logic      [cfgpp_pkg::DATA_W-1:0]      cfg_byte_data,          // byte to engine
   output logic                                   cfg_byte_valid,         // byte waiting
   input  wire logic                              cfg_byte_ready,         // engine takes byte
   input  wire logic                              cfg_data_error,         // engine saw bad data
   input  wire logic                              cfg_done,               // engine finished
   output logic      [2:0]                        cfg_mode,               // sampled mode
   output logic                                   configuring,            // in configuration
   output logic                                   serial_enable,          // express chain enable
   output logic                                   user_io_enable          // pins handed to user
);

   import cfgpp_pkg::*;

   // refuse values the 16-bit sequencing counter cannot serve
   if (CLEAR_CYC < 1 || CLEAR_CYC > 65535) begin : g_bad_clear
      $error("CLEAR_CYC out of range");
   end
   if (MASTER_WAIT_CYC > MASTER_WAIT_MAX_CYC || MASTER_WAIT_CYC > 65535) begin : g_bad_wait
      $error("master wait exceeds its longest time");
   end

   function automatic logic is_master(input logic [2:0] m);
      is_master = (m == MODE_MASTER_SER) || (m == MODE_MASTER_PAR);
   endfunction

   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   logic [PIN_W-1:0] pins_s;

   cfgpp_sync3 #(
      .W   (PIN_W),
      .RST (PIN_RST)
   ) u_sync (
      .clk    (clk),
      .rst_b  (rst_b),
      .pin_in ({config_mode_select, peripheral_data_in, read_strobe_n, write_strobe_n,
                chip_select_high, chip_select_low, init_in}),
      .pin_s  (pins_s)
   );

   logic              init_s;
   logic              ws_s;
   logic              rs_s;
   logic [DATA_W-1:0] data_s;
   logic [2:0]        mode_s;
   logic              selected;
   assign init_s   = pins_s[PIN_INIT];
   assign ws_s     = pins_s[PIN_WS];
   assign rs_s     = pins_s[PIN_RS];
   assign data_s   = pins_s[PIN_DATA +: DATA_W];
   assign mode_s   = pins_s[PIN_MODE +: 3];
   assign selected = !pins_s[PIN_CSL] && pins_s[PIN_CSH];

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   cfgpp_state_type state_q;
   logic [15:0]     cnt_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_CLEAR;
         cnt_q   <= 16'h0000;
      end else begin
         case (state_q)
            ST_CLEAR: begin
               if (cnt_q == 16'(CLEAR_CYC - 1)) begin
                  state_q <= ST_WAIT;
                  cnt_q   <= 16'h0000;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ST_WAIT: begin
               if (init_s) begin
                  state_q <= is_master(mode_s) ? ST_MDELAY : ST_CONFIG;
               end
            end
            ST_MDELAY: begin
               if (cnt_q == 16'(MASTER_WAIT_CYC - 1)) begin
                  state_q <= ST_CONFIG;
                  cnt_q   <= 16'h0000;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ST_CONFIG: begin
               if (cfg_data_error) begin
                  state_q <= ST_ERROR;
               end else if (cfg_done) begin
                  state_q <= ST_DONE;
               end
            end
            ST_ERROR: state_q <= ST_ERROR;
            ST_DONE:  state_q <= ST_DONE;
            default:  state_q <= ST_CLEAR;
         endcase
      end
   end

   // mode captured as the clear/hold pin is seen high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_mode <= MODE_SLAVE_SER;
      end else if (state_q == ST_WAIT && init_s) begin
         cfg_mode <= mode_s;
      end
   end

   // open-drain clear/hold pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         init_out <= 1'b0;
         init_oe  <= 1'b1;
      end else begin
         init_out <= 1'b0;
         init_oe  <= (state_q == ST_CLEAR && cnt_q != 16'(CLEAR_CYC - 1))
                     || (state_q == ST_CONFIG && cfg_data_error)
                     || state_q == ST_ERROR;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         configuring    <= 1'b0;
         user_io_enable <= 1'b0;
         serial_enable  <= 1'b0;
      end else begin
         configuring    <= (state_q == ST_CONFIG);
         user_io_enable <= (state_q == ST_DONE);
         serial_enable  <= (state_q == ST_CONFIG) && (cfg_mode == MODE_EXPRESS)
                           && pins_s[PIN_CSH];
      end
   end

   // ------------------------------------------------------------
   // asynchronous peripheral port
   // ------------------------------------------------------------
   logic periph_on;
   logic ws_prev_q;
   logic wr_fire;
   logic rd_req;
   logic buf_full_d;
   assign periph_on = (state_q == ST_CONFIG) && (cfg_mode == MODE_PERIPH);
   assign wr_fire   = periph_on && selected && ws_prev_q && !ws_s && !cfg_byte_valid;
   assign rd_req    = periph_on && selected && !rs_s && ws_s;

   always_comb begin
      buf_full_d = cfg_byte_valid;
      if (cfg_byte_valid && cfg_byte_ready) begin
         buf_full_d = 1'b0;
      end
      if (wr_fire) begin
         buf_full_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ws_prev_q      <= 1'b1;
         cfg_byte_valid <= 1'b0;
         cfg_byte_data  <= 8'h00;
      end else begin
         ws_prev_q      <= ws_s;
         cfg_byte_valid <= buf_full_d;
         if (wr_fire) begin
            cfg_byte_data <= data_s;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         byte_accept_indicator <= 1'b1;
         byte_accept_oe        <= 1'b0;
      end else begin
         byte_accept_indicator <= !buf_full_d;
         byte_accept_oe        <= (state_q == ST_CONFIG) && (cfg_mode == MODE_PERIPH);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         peripheral_data_out <= 8'hFF;
         peripheral_data_oe  <= 1'b0;
      end else begin
         peripheral_data_out <= {byte_accept_indicator, STATUS_FILL};
         peripheral_data_oe  <= rd_req;
      end
   end

   // ------------------------------------------------------------
   // master parallel rom addressing
   // ------------------------------------------------------------
   logic [ADDR_W+ADDR_EXT_W-1:0] addr_q;
   logic                         par_on;
   assign par_on = (state_q == ST_CONFIG) && (cfg_mode == MODE_MASTER_PAR);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_q <= '0;
      end else if (par_on && rom_next) begin
         addr_q <= addr_q + 22'h000001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         config_rom_address     <= 18'h00000;
         config_rom_address_ext <= 4'h0;
         rom_addr_oe            <= 1'b0;
      end else begin
         config_rom_address     <= addr_q[ADDR_W-1:0];
         config_rom_address_ext <= WIDE_ADDR ? addr_q[ADDR_W +: ADDR_EXT_W] : 4'h0;
         rom_addr_oe            <= par_on;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_pin_release;
      state_q == ST_WAIT && init_s && is_master(mode_s);
   endsequence

   sequence s_master_hold;
      state_q == ST_MDELAY [*8];
   endsequence

   a_clear_drive: assert property (state_q == ST_CLEAR && cnt_q != 16'(CLEAR_CYC - 1)
                                   |=> init_oe && !init_out)
      else $error("clear/hold pin not driven low during clearing");
   a_wait_hold: assert property (state_q == ST_WAIT && !init_s |=> state_q == ST_WAIT)
      else $error("left wait state while pin held low");
   a_master_delay: assert property (s_pin_release |=> s_master_hold)
      else $error("master wait too short");
   a_master_exit: assert property ($fell(state_q == ST_MDELAY) |-> $past(cnt_q) == 16'(MASTER_WAIT_CYC - 1))
      else $error("master wait left at wrong count");
   a_error_low: assert property (state_q == ST_CONFIG && cfg_data_error |=> init_oe ##1 init_oe)
      else $error("data error not signalled on clear/hold pin");
   a_status_byte: assert property (peripheral_data_oe |-> $past(selected) && !$past(rs_s)
                                   && peripheral_data_out[6:0] == 7'h7F)
      else $error("status read driven wrongly");
   a_write_wins: assert property (!ws_s && !rs_s |=> !peripheral_data_oe)
      else $error("read answered during write");
   a_byte_capture: assert property (wr_fire |=> cfg_byte_valid && !byte_accept_indicator
                                    && cfg_byte_data == $past(data_s))
      else $error("byte not captured or busy not shown");
   a_ready_back: assert property (cfg_byte_valid && cfg_byte_ready && !wr_fire |=> byte_accept_indicator)
      else $error("ready not restored after byte taken");
   a_addr_step: assert property (par_on && rom_next |=> addr_q == $past(addr_q) + 22'h000001
                                 ##1 config_rom_address == $past(addr_q[ADDR_W-1:0]))
      else $error("rom address did not advance");
   a_release: assert property (state_q == ST_DONE |=> user_io_enable && !peripheral_data_oe
                               && !rom_addr_oe && !byte_accept_oe)
      else $error("pins not released after configuration");
   a_mode_sample: assert property (state_q == ST_WAIT && init_s |=> cfg_mode == $past(mode_s))
      else $error("mode not sampled at pin release");

endmodule

// ---- cfgpp_host_model.sv ----
// host processor model on the asynchronous peripheral port
// assumes the bench calls its tasks; all pins change at the falling clock edge
`timescale 1ns/100ps
module cfgpp_host_model (
   input  wire logic        clk,              // bench clock
   input  wire logic [7:0]  dev_data,         // device data drive value
   input  wire logic        dev_oe,           // device data drive enable
   input  wire logic        indicator,        // ready/busy pin
   output logic             chip_select_low,  // select, active low
   output logic             chip_select_high, // select, active high
   output logic             write_strobe_n,   // write strobe
   output logic             read_strobe_n,    // read strobe
   output logic      [7:0]  bus               // resolved data bus level
);
   logic [7:0] drv;
   logic       drv_en;
   logic [7:0] last;

   // ------------------------------------------------------------
   // bus resolution: released bus shows the inverse of the last byte
   // ------------------------------------------------------------
   assign bus = dev_oe ? dev_data : (drv_en ? drv : ~last);

   initial begin
      chip_select_low  = 1'b1;
      chip_select_high = 1'b0;
      write_strobe_n   = 1'b1;
      read_strobe_n    = 1'b1;
      drv              = 8'h00;
      drv_en           = 1'b0;
      last             = 8'h00;
   end

   // ------------------------------------------------------------
   // byte write; holds until busy appears or 8 cycles pass
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] b, input logic csl_v, input logic csh_v, input logic both,
                     output logic saw_oe);
      logic prev;
      logic got;
      int   i;
      @(negedge clk);
      chip_select_low  = csl_v;
      chip_select_high = csh_v;
      drv              = b;
      drv_en           = 1'b1;
      write_strobe_n   = 1'b0;
      read_strobe_n    = ~both;
      prev             = indicator;
      got              = 1'b0;
      saw_oe           = 1'b0;
      for (i = 0; i < 8 && !got; i++) begin
         @(negedge clk);
         got    = prev && !indicator;
         prev   = indicator;
         saw_oe = saw_oe | dev_oe;
      end
      write_strobe_n   = 1'b1;
      read_strobe_n    = 1'b1;
      drv_en           = 1'b0;
      last             = b;
      chip_select_low  = 1'b1;
      chip_select_high = 1'b0;
      repeat (6) @(negedge clk);
   endtask

   // ------------------------------------------------------------
   // status read; takes data once the device drives the bus
   // ------------------------------------------------------------
   task automatic rd(output logic [7:0] v, output logic got);
      int i;
      @(negedge clk);
      chip_select_low  = 1'b0;
      chip_select_high = 1'b1;
      read_strobe_n    = 1'b0;
      got              = 1'b0;
      v                = 8'h00;
      for (i = 0; i < 10 && !got; i++) begin
         @(negedge clk);
         if (dev_oe === 1'b1) begin
            got = 1'b1;
            v   = dev_data;
         end
      end
      read_strobe_n    = 1'b1;
      chip_select_low  = 1'b1;
      chip_select_high = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic sel_high(input logic v);
      @(negedge clk);
      chip_select_high = v;
   endtask
endmodule

// ---- tb.sv ----
// self-checking bench of the configuration loader
// assumes the host model drives the peripheral port, the bench plays the engine
`timescale 1ns/100ps
module tb;
   import cfgpp_pkg::*;
   logic        clk, rst_b, hold, init_in, init_out, init_oe, rom_next, ready, err, done;
   logic [2:0]  mode, cfg_mode;
   logic        csl, csh, ws_n, rs_n, d_oe, ind, ind_oe, a_oe, valid, configuring, ser_en, user_en;
   logic [7:0]  d_in, d_out, c_data, v;
   logic [17:0] addr;
   logic [3:0]  addr_ext;
   logic        s, g;
   int          fails, tests_run, cycles, n;

   // open-drain wire with pull-up, held low by either party
   assign init_in = ~((init_oe & ~init_out) | hold);

   cfgpp_loader #(.CLEAR_CYC(2), .WIDE_ADDR(1'b1)) dut (
      .clk(clk), .rst_b(rst_b), .init_in(init_in), .init_out(init_out), .init_oe(init_oe),
      .config_mode_select(mode), .chip_select_low(csl), .chip_select_high(csh),
      .write_strobe_n(ws_n), .read_strobe_n(rs_n), .peripheral_data_in(d_in),
      .peripheral_data_out(d_out), .peripheral_data_oe(d_oe), .byte_accept_indicator(ind),
      .byte_accept_oe(ind_oe), .config_rom_address(addr), .config_rom_address_ext(addr_ext),
      .rom_addr_oe(a_oe), .rom_next(rom_next), .cfg_byte_data(c_data), .cfg_byte_valid(valid),
      .cfg_byte_ready(ready), .cfg_data_error(err), .cfg_done(done), .cfg_mode(cfg_mode),
      .configuring(configuring), .serial_enable(ser_en), .user_io_enable(user_en));

   cfgpp_host_model host (
      .clk(clk), .dev_data(d_out), .dev_oe(d_oe), .indicator(ind), .chip_select_low(csl),
      .chip_select_high(csh), .write_strobe_n(ws_n), .read_strobe_n(rs_n), .bus(d_in));

   // ------------------------------------------------------------
   // common tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic do_reset(input logic [2:0] m, input logic h);
      @(negedge clk);
      rst_b = 1'b0;
      mode  = m;
      hold  = h;
      repeat (4) @(negedge clk);
      check("init_oe_rst", init_oe, 1);
      check("ind_rst", ind, 1);
      rst_b = 1'b1;
      @(negedge clk);
      check("init_oe_clear", init_oe, 1);
   endtask

   task automatic wait_cfg(output int k);
      for (k = 0; k < 3100 && configuring !== 1'b1; k++) @(negedge clk);
      check("configuring", configuring, 1);
   endtask

   task automatic take_byte;
      @(negedge clk) ready = 1'b1;
      @(negedge clk) ready = 1'b0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_hold_wait;
      do_reset(MODE_PERIPH, 1'b1);
      repeat (40) @(negedge clk);
      check("cfg_held", configuring, 0);
      check("init_oe_off", init_oe, 0);
      hold = 1'b0;
      wait_cfg(n);
      check("cfg_mode", cfg_mode, MODE_PERIPH);
      check("ind_oe", ind_oe, 1);
   endtask

   task automatic t_write_busy;
      host.wr(8'hA5, 1'b0, 1'b1, 1'b0, s);
      check("valid", valid, 1);
      check("byte", c_data, 8'hA5);
      check("busy", ind, 0);
      host.wr(8'h3C, 1'b0, 1'b1, 1'b0, s);
      check("byte_kept", c_data, 8'hA5);
      host.rd(v, g);
      check("rd_busy_got", g, 1);
      check("rd_busy", v, {1'b0, STATUS_FILL});
      take_byte();
      @(negedge clk);
      check("valid_gone", valid, 0);
      check("ready", ind, 1);
      host.rd(v, g);
      check("rd_ready_got", g, 1);
      check("rd_ready", v, {1'b1, STATUS_FILL});
   endtask

   task automatic t_select;
      host.wr(8'h11, 1'b1, 1'b1, 1'b0, s);
      check("csl_high", valid, 0);
      host.wr(8'h22, 1'b0, 1'b0, 1'b0, s);
      check("csh_low", valid, 0);
   endtask

   task automatic t_both;
      host.wr(8'h5A, 1'b0, 1'b1, 1'b1, s);
      check("both_no_rd", s, 0);
      check("both_byte", c_data, 8'h5A);
      check("both_valid", valid, 1);
      take_byte();
   endtask

   task automatic t_error;
      @(negedge clk) err = 1'b1;
      @(negedge clk) err = 1'b0;
      @(negedge clk);
      check("err_pull", init_oe, 1);
      check("err_wire", init_in, 0);
   endtask

   task automatic t_done;
      do_reset(MODE_PERIPH, 1'b0);
      wait_cfg(n);
      @(negedge clk) done = 1'b1;
      @(negedge clk) done = 1'b0;
      repeat (3) @(negedge clk);
      check("user_io", user_en, 1);
      check("ind_oe_off", ind_oe, 0);
   endtask

   task automatic t_master;
      do_reset(MODE_MASTER_SER, 1'b0);
      for (n = 0; n < 20 && init_in !== 1'b1; n++) @(negedge clk);
      wait_cfg(n);
      check("ser_wait_min", n >= MASTER_WAIT_CYC, 1);
      check("ser_wait_max", n <= MASTER_WAIT_MAX_CYC, 1);
      check("ser_mode", cfg_mode, MODE_MASTER_SER);
      check("ser_addr_oe", a_oe, 0);
      do_reset(MODE_MASTER_PAR, 1'b0);
      for (n = 0; n < 20 && init_in !== 1'b1; n++) @(negedge clk);
      wait_cfg(n);
      check("wait_min", n >= MASTER_WAIT_CYC, 1);
      check("wait_max", n <= MASTER_WAIT_MAX_CYC, 1);
      check("addr_oe", a_oe, 1);
      @(negedge clk) rom_next = 1'b1;
      repeat (3) @(negedge clk);
      rom_next = 1'b0;
      repeat (3) @(negedge clk);
      check("addr", addr, 18'h00003);
      check("addr_ext", addr_ext, 4'h0);
   endtask

   task automatic t_express;
      do_reset(MODE_EXPRESS, 1'b0);
      wait_cfg(n);
      host.sel_high(1'b1);
      repeat (6) @(negedge clk);
      check("ser_en_on", ser_en, 1);
      host.sel_high(1'b0);
      repeat (6) @(negedge clk);
      check("ser_en_off", ser_en, 0);
   endtask

   // ------------------------------------------------------------
   // clock, timeout and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles >= 5000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      {rst_b, hold, rom_next, ready, err, done} = 6'h00;
      mode      = MODE_PERIPH;
      fails     = 0;
      tests_run = 0;
      cycles    = 0;
      t_hold_wait();
      t_write_busy();
      t_select();
      t_both();
      t_error();
      t_done();
      t_master();
      t_express();
      end_of_test();
   end
endmodule
